// [logic/pom_meter.sv]
// phase offset meter: signed A-edge to B-edge offset in timebase ticks
// assumes control strobes are one-cycle pulses on clk_sys and that
// clock sources are far slower than clk_sys so they can be sampled
// offsets through output clocks carry a fixed fast-divider skew that
// software removes; the count itself does not depend on the path
// unused select codes read low and produce no edges
`timescale 1ns/1ps

module pom_meter import pom_pkg::*; (
  // system
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // clock and pin sources
  input  wire logic [POM_NUM_IN-1:0]  input_clock_n,
  input  wire logic [POM_NUM_OUT-1:0] output_clock_n,
  input  wire logic [POM_NUM_PIN-1:0] gpio_pin,
  // timebase sources
  input  wire logic                   osc_clk,
  input  wire logic                   osc_dbl_clk,
  input  wire logic                   mid_divider_one,
  input  wire logic                   mid_divider_two,
  input  wire logic                   mid_divider_three,
  // configuration fields
  input  wire logic [POM_SEL_W-1:0]   first_signal_select,
  input  wire logic [POM_SEL_W-1:0]   second_signal_select,
  input  wire logic [POM_TB_W-1:0]    timebase_select,
  input  wire logic                   first_edge_fall,
  input  wire logic                   second_edge_fall,
  input  wire logic                   second_edge_invert,
  // control strobes
  input  wire logic                   start_wr,
  input  wire logic                   abort_wr,
  input  wire logic                   ready_clr_wr,
  input  wire logic                   overflow_clr_wr,
  // status registers
  output logic      [7:0]             offset_count_status_one,
  output logic      [7:0]             offset_count_status_two
);

  // sampled sources
  logic [POM_NUM_SRC-1:0] src_raw;
  logic [POM_NUM_SRC-1:0] src_smp;
  logic [POM_NUM_IN-1:0]  smp_in;
  logic [POM_NUM_OUT-1:0] smp_out;
  logic [POM_NUM_PIN-1:0] smp_pin;
  logic [POM_NUM_TB-1:0]  smp_tb;

  // selected levels and edges
  logic                   a_lvl;
  logic                   b_lvl;
  logic                   tb_lvl;
  logic                   tb_tick;
  logic                   a_edge;
  logic                   b_edge;
  logic                   b_fall;
  logic                   tb_pick_osc;
  logic                   tb_pick_dbl;
  logic                   tb_pick_mid1;
  logic                   tb_pick_mid2;
  logic                   tb_pick_mid3;
  logic                   a_moved;
  logic                   b_moved;

  // state and counters
  pom_state_e             state_r;
  pom_state_e             state_nxt;
  logic                   tb_prev_r;
  logic                   a_prev_r;
  logic                   b_prev_r;
  logic [POM_CNT_W-1:0]   age_r;
  logic [POM_CNT_W-1:0]   age_nxt;
  logic [POM_CNT_W-1:0]   age_cap_r;
  logic [POM_CNT_W-1:0]   age_cap_nxt;
  logic [POM_CNT_W-1:0]   after_r;
  logic [POM_CNT_W-1:0]   after_nxt;
  logic [POM_CNT_W-1:0]   age_dist;
  logic [POM_CNT_W-1:0]   after_dist;
  logic [POM_CNT_W-1:0]   neg_val;

  // outcomes of one tick while waiting for B
  logic                   b_near;
  logic                   b_passed;
  logic                   b_lost;

  // completion and flags
  logic                   done;
  logic                   done_ovf;
  logic [POM_RES_W-1:0]   done_val;
  logic [POM_RES_W-1:0]   result_r;
  logic [POM_RES_W-1:0]   result_nxt;
  logic                   ready_r;
  logic                   ready_nxt;
  logic                   ovf_r;
  logic                   ovf_nxt;
  logic                   busy;
  logic                   busy_nxt;
  logic [7:0]             status_one_nxt;
  logic [7:0]             status_two_nxt;

  // order here fixes the group positions used by the split below
  // gather all sources into one vector for the sampler
  assign src_raw = {mid_divider_three, mid_divider_two, mid_divider_one,
                    osc_dbl_clk, osc_clk, gpio_pin, output_clock_n, input_clock_n};

  // every source sees the same two-stage delay, so relative timing holds
  // synchronise every source
  pom_sampler u_sampler (
    .clk_sys (clk_sys),
    .rst     (rst),
    .src_raw (src_raw),
    .src_smp (src_smp)
  );

  // split sampled vector back into groups
  assign smp_in  = src_smp[POM_POS_IN  +: POM_NUM_IN];
  assign smp_out = src_smp[POM_POS_OUT +: POM_NUM_OUT];
  assign smp_pin = src_smp[POM_POS_PIN +: POM_NUM_PIN];
  assign smp_tb  = src_smp[POM_POS_TB  +: POM_NUM_TB];

  // source decode: output, pin or input clock; unmapped codes read low
  function automatic logic pick_src(input logic [POM_SEL_W-1:0] code,
                                    input logic [POM_NUM_IN-1:0]  vin,
                                    input logic [POM_NUM_OUT-1:0] vout,
                                    input logic [POM_NUM_PIN-1:0] vpin);
    logic v;
    logic is_out;
    logic is_pin;
    logic is_in;
    // outputs need bits 3:2 clear; inputs need bits 4:2 clear
    is_out = code[POM_SEL_OUT_B] && (code[3:2] == 2'b00) && (code[1:0] < 2'(POM_NUM_OUT));
    is_pin = !code[POM_SEL_OUT_B] && code[POM_SEL_PIN_B];
    is_in  = (code[4:2] == 3'b000);
    v      = 1'b0;
    if (is_out) begin
      v = vout[code[1:0]];
    end else if (is_pin) begin
      v = vpin[code[2:0]];
    end else if (is_in) begin
      v = vin[code[1:0]];
    end
    return v;
  endfunction

  // independent A and B source selection
  assign a_lvl = pick_src(first_signal_select, smp_in, smp_out, smp_pin);
  assign b_lvl = pick_src(second_signal_select, smp_in, smp_out, smp_pin);

  // timebase source selection; unused codes give no ticks
  assign tb_pick_osc  = (timebase_select == POM_TB_OSC);
  assign tb_pick_mid1 = (timebase_select == POM_TB_MID1);
  assign tb_pick_mid2 = (timebase_select == POM_TB_MID2);
  assign tb_pick_mid3 = (timebase_select == POM_TB_MID3);
  assign tb_pick_dbl  = (timebase_select == POM_TB_OSC_DBL);
  assign tb_lvl = (tb_pick_osc & smp_tb[0]) | (tb_pick_dbl & smp_tb[1]) | (tb_pick_mid1 & smp_tb[2]) |
                  (tb_pick_mid2 & smp_tb[3]) | (tb_pick_mid3 & smp_tb[4]);

  // one tick per rising timebase edge; A and B judged only on ticks
  assign tb_tick = tb_lvl & ~tb_prev_r;
  assign a_moved = a_lvl ^ a_prev_r;
  assign a_edge  = tb_tick & a_moved & (a_lvl ^ first_edge_fall);

  // invert flips which B edge is the target
  assign b_fall  = second_edge_fall ^ second_edge_invert;
  assign b_moved = b_lvl ^ b_prev_r;
  assign b_edge  = tb_tick & b_moved & (b_lvl ^ b_fall);

  // output paths count the same way; divider skew stays outside
  // all sources share one sampler depth so path delays cancel
  // distances in ticks; the counters lag by one so add one here
  assign age_dist   = (age_r == POM_CNT_SAT) ? POM_CNT_SAT : age_r + POM_CNT_ONE;
  assign after_dist = after_r + POM_CNT_ONE;
  assign neg_val    = (~age_cap_r) + POM_CNT_ONE;

  assign b_near   = b_edge && (after_dist <= age_cap_r);
  assign b_passed = after_dist > age_cap_r;
  assign b_lost   = after_dist > POM_NEG_MAX;

  // measurement sequencer
  always_comb begin
    state_nxt   = state_r;
    age_nxt     = age_r;
    age_cap_nxt = age_cap_r;
    after_nxt   = after_r;
    done        = 1'b0;
    done_ovf    = 1'b0;
    done_val    = POM_RES_RST;
    // age of last B edge, saturating; unknown until first B edge
    if (busy && tb_tick) begin
      if (b_edge) begin
        age_nxt = '0;
      end else if (age_r != POM_CNT_SAT) begin
        age_nxt = age_r + POM_CNT_ONE;
      end
    end
    case (state_r)
      POM_IDLE: begin
        if (start_wr) begin
          state_nxt = POM_WAIT_A;
          age_nxt   = POM_CNT_SAT;
        end
      end
      POM_WAIT_A: begin
        // a B edge on this very tick is skipped, so the
        // captured age is the full B period when edges coincide
        if (a_edge) begin
          state_nxt   = POM_WAIT_B;
          age_cap_nxt = age_dist;
          after_nxt   = '0;
        end
      end
      POM_WAIT_B: begin
        if (tb_tick) begin
          if (after_r != POM_CNT_SAT) begin
            after_nxt = after_dist;
          end
          if (b_near) begin
            // positive offset overflows past the 11-bit range
            done     = 1'b1;
            done_ovf = after_dist > POM_POS_MAX;
            done_val = after_dist[POM_RES_W-1:0];
          end else if (b_passed) begin
            // earlier B edge is nearer: negative result
            done     = 1'b1;
            done_ovf = age_cap_r > POM_NEG_MAX;
            done_val = neg_val[POM_RES_W-1:0];
          end else if (b_lost) begin
            // coincident edges on a slow B end here as overflow
            done     = 1'b1;
            done_ovf = 1'b1;
          end
          if (done) begin
            state_nxt = POM_IDLE;
          end
        end
      end
      default: begin
        state_nxt = POM_IDLE;
      end
    endcase
    // abort wins over everything and returns to idle
    if (abort_wr) begin
      state_nxt = POM_IDLE;
      done      = 1'b0;
    end
  end

  // busy is live state; ready latches on completion
  // busy reflects the sequencer directly, so status shows no extra lag
  assign busy     = (state_r != POM_IDLE);
  assign busy_nxt = (state_nxt != POM_IDLE);

  // a clear that beat a completion would hide a fresh result
  // write-one clear; a completion in the same cycle wins
  assign ready_nxt = done | (ready_r & ~ready_clr_wr);
  assign ovf_nxt   = (done & done_ovf) | (ovf_r & ~overflow_clr_wr);

  // result held until valid completion; abort clears it
  assign result_nxt = abort_wr ? POM_RES_RST :
                      (done & ~done_ovf) ? done_val : result_r;

  // sequencer registers
  // age starts saturated: before any B edge the last one counts as far away
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r   <= POM_IDLE;
      age_r     <= POM_CNT_SAT;
      age_cap_r <= POM_CNT_SAT;
      after_r   <= '0;
    end else begin
      state_r   <= state_nxt;
      age_r     <= age_nxt;
      age_cap_r <= age_cap_nxt;
      after_r   <= after_nxt;
    end
  end

  // previous sampled levels; timebase updated every cycle, A and B on timebase ticks only
  // judging on ticks only snaps A and B edges to the timebase grid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tb_prev_r <= 1'b0;
      a_prev_r  <= 1'b0;
      b_prev_r  <= 1'b0;
    end else begin
      tb_prev_r <= tb_lvl;
      if (tb_tick) begin
        a_prev_r <= a_lvl;
        b_prev_r <= b_lvl;
      end
    end
  end

  // latched flags and result
  // flags and result share one edge so status never shows them apart
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ready_r  <= 1'b0;
      ovf_r    <= 1'b0;
      result_r <= POM_RES_RST;
    end else begin
      ready_r  <= ready_nxt;
      ovf_r    <= ovf_nxt;
      result_r <= result_nxt;
    end
  end

  // status words as they stand after this edge
  assign status_one_nxt = {result_nxt[POM_RES_W-1:8], 2'b00, ovf_nxt, ready_nxt, busy_nxt};
  assign status_two_nxt = result_nxt[7:0];

  // status registers: flags and result bits 10:8, then bits 7:0
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      offset_count_status_one <= 8'h00;
      offset_count_status_two <= 8'h00;
    end else begin
      offset_count_status_one <= status_one_nxt;
      offset_count_status_two <= status_two_nxt;
    end
  end

endmodule // pom_meter

// [logic/pom_pkg.sv]
// constants, codes and state type of the phase offset meter
// assumes one system clock; shared by the meter and its input sampler
package pom_pkg;

  // source counts
  localparam int POM_NUM_IN  = 4;
  localparam int POM_NUM_OUT = 3;
  localparam int POM_NUM_PIN = 8;
  localparam int POM_NUM_TB  = 5;
  localparam int POM_NUM_SRC = POM_NUM_IN + POM_NUM_OUT + POM_NUM_PIN + POM_NUM_TB;

  // positions of each group in the sampled source vector
  localparam int POM_POS_IN  = 0;
  localparam int POM_POS_OUT = POM_POS_IN + POM_NUM_IN;
  localparam int POM_POS_PIN = POM_POS_OUT + POM_NUM_OUT;
  localparam int POM_POS_TB  = POM_POS_PIN + POM_NUM_PIN;

  // synchroniser depth
  localparam int POM_SYNC_STAGES = 2;

  // signal source select: bit 4 output clock, bit 3 pin, bits 4:2 clear input clock, other codes read low
  localparam int          POM_SEL_W      = 5;
  localparam int          POM_SEL_OUT_B  = 4;
  localparam int          POM_SEL_PIN_B  = 3;
  localparam logic [4:0]  POM_SEL_OUT1   = 5'h10;
  localparam logic [4:0]  POM_SEL_OUT2   = 5'h11;

  // timebase select codes
  localparam int          POM_TB_W       = 3;
  localparam logic [2:0]  POM_TB_OSC     = 3'h0;
  localparam logic [2:0]  POM_TB_MID1    = 3'h1;
  localparam logic [2:0]  POM_TB_MID2    = 3'h2;
  localparam logic [2:0]  POM_TB_MID3    = 3'h3;
  localparam logic [2:0]  POM_TB_OSC_DBL = 3'h4;

  // counters and result
  localparam int          POM_CNT_W      = 12;
  localparam logic [11:0] POM_CNT_SAT    = 12'hfff;
  localparam logic [11:0] POM_CNT_ONE    = 12'h001;
  localparam logic [11:0] POM_POS_MAX    = 12'h3ff;
  localparam logic [11:0] POM_NEG_MAX    = 12'h400;
  localparam int          POM_RES_W      = 11;
  localparam logic [10:0] POM_RES_RST    = 11'h000;

  // status register one layout; status two holds result bits 7:0
  localparam int POM_ST_BUSY = 0;
  localparam int POM_ST_RDY  = 1;
  localparam int POM_ST_OVF  = 2;
  localparam int POM_ST_RES  = 5;

  // measurement states
  typedef enum logic [2:0] {
    POM_IDLE   = 3'b001,
    POM_WAIT_A = 3'b010,
    POM_WAIT_B = 3'b100
  } pom_state_e;

endpackage

// [logic/pom_sampler.sv]
// two-stage synchroniser for every clock and pin source of the meter
// assumes the sources are unrelated to clk_sys
`timescale 1ns/1ps

module pom_sampler import pom_pkg::*; (
  // system
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // raw and sampled sources
  input  wire logic [POM_NUM_SRC-1:0] src_raw,
  output logic      [POM_NUM_SRC-1:0] src_smp
);

  // one synchroniser chain per source bit
  genvar gi;
  generate
    for (gi = 0; gi < POM_NUM_SRC; gi++) begin : g_sync
      logic [POM_SYNC_STAGES-1:0] chain_r;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          chain_r <= '0;
        end else begin
          chain_r <= {chain_r[POM_SYNC_STAGES-2:0], src_raw[gi]};
        end
      end
      assign src_smp[gi] = chain_r[POM_SYNC_STAGES-1];
    end
  endgenerate

endmodule // pom_sampler

// [verification/pom_meter_checker.sv]
// concurrent checks on the status ports of the phase offset meter
// assumes one clock domain and the active-high asynchronous reset
`timescale 1ns/1ps

module pom_meter_checker import pom_pkg::*; (
  // system
  input wire logic       clk_sys,
  input wire logic       rst,
  // control strobes
  input wire logic       start_wr,
  input wire logic       abort_wr,
  input wire logic       ready_clr_wr,
  input wire logic       overflow_clr_wr,
  // status registers
  input wire logic [7:0] offset_count_status_one,
  input wire logic [7:0] offset_count_status_two
);
  default clocking dck @(posedge clk_sys); endclocking
  default disable iff (rst);

  // status fields
  wire        busy = offset_count_status_one[POM_ST_BUSY];
  wire        rdy  = offset_count_status_one[POM_ST_RDY];
  wire        ovf  = offset_count_status_one[POM_ST_OVF];
  wire [10:0] res  = {offset_count_status_one[7:5], offset_count_status_two};

  // start taken while idle, completion not caused by abort
  sequence s_go;
    !busy && start_wr && !abort_wr;
  endsequence
  sequence s_end;
    $fell(busy) && !$past(abort_wr);
  endsequence

  AST_PAD_ZERO: assert property (offset_count_status_one[4:3] == 2'h0)
    else $error("status pad bits set");
  AST_START_BUSY: assert property (s_go |=> busy)
    else $error("start did not raise busy");
  AST_ABORT_IDLE: assert property (busy && abort_wr |=> !busy && res == 11'h000)
    else $error("abort did not idle and clear result");
  AST_DONE_READY: assert property (s_end |-> rdy)
    else $error("completion without ready");
  AST_RDY_HOLD: assert property (rdy && !ready_clr_wr |=> rdy)
    else $error("ready dropped without clear");
  AST_RDY_CLEAR: assert property (ready_clr_wr && !busy |=> !rdy)
    else $error("ready clear ignored");
  AST_OVF_CLEAR: assert property (overflow_clr_wr && !busy |=> !ovf)
    else $error("overflow clear ignored");
  AST_OVF_AT_END: assert property ($rose(ovf) |-> $fell(busy))
    else $error("overflow set outside completion");
  AST_RES_STABLE: assert property (!busy && !abort_wr |=> $stable(res))
    else $error("result changed while idle");
endmodule // pom_meter_checker

bind pom_meter pom_meter_checker chk_u (
  .clk_sys         (clk_sys),
  .rst             (rst),
  .start_wr        (start_wr),
  .abort_wr        (abort_wr),
  .ready_clr_wr    (ready_clr_wr),
  .overflow_clr_wr (overflow_clr_wr),
  .offset_count_status_one (offset_count_status_one),
  .offset_count_status_two (offset_count_status_two)
);

// [verification/pom_meter_bench.sv]
// self-checking bench of the phase offset meter with a tick-level model
// assumes one timebase tick per 8 clk_sys cycles, far above sampler delay
`timescale 1ns/1ps

module pom_meter_bench import pom_pkg::*;;
  // stimulus and status
  logic        clk_sys     = 1'h0;
  logic        rst         = 1'h1;
  logic [14:0] src         = 15'h0000; // in 3:0, out 6:4, pin 14:7
  logic [4:0]  tbs         = 5'h00;    // osc, mid one..three, doubled
  logic [4:0]  sel_a       = 5'h00;
  logic [4:0]  sel_b       = 5'h10;
  logic [2:0]  tb_sel      = 3'h0;
  logic        fa          = 1'h0;
  logic        fb          = 1'h0;
  logic        inv         = 1'h0;
  logic [3:0]  strb        = 4'h0;     // ovf clr, rdy clr, abort, start
  logic [7:0]  st1;
  logic [7:0]  st2;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          seed        = 32'hcd6370e3;
  int          last_res    = 0;

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  pom_meter dut_u (
    .clk_sys(clk_sys), .rst(rst),
    .input_clock_n(src[3:0]), .output_clock_n(src[6:4]), .gpio_pin(src[14:7]),
    .osc_clk(tbs[0]), .osc_dbl_clk(tbs[4]),
    .mid_divider_one(tbs[1]), .mid_divider_two(tbs[2]), .mid_divider_three(tbs[3]),
    .first_signal_select(sel_a), .second_signal_select(sel_b), .timebase_select(tb_sel),
    .first_edge_fall(fa), .second_edge_fall(fb), .second_edge_invert(inv),
    .start_wr(strb[0]), .abort_wr(strb[1]), .ready_clr_wr(strb[2]), .overflow_clr_wr(strb[3]),
    .offset_count_status_one(st1), .offset_count_status_two(st2)
  );

  function automatic int rnd(int n);
    return int'($unsigned($random(seed)) % n);
  endfunction
  // B level at tick t, held low when pb is zero
  function automatic logic blv(int t, int pb, int off);
    return pb > 0 && ((t + off) % pb) < pb / 2;
  endfunction
  function automatic int idx(logic [4:0] c);
    return c[4] ? 4 + int'(c[1:0]) : (c[3] ? 7 + int'(c[2:0]) : int'(c[1:0]));
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_flag(string what, logic want, logic got);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic chk_res(string what, logic [10:0] want, logic [10:0] got);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic pulse(logic [3:0] s);
    @(negedge clk_sys);
    strb = s;
    @(negedge clk_sys);
    strb = 4'h0;
  endtask
  // one timebase tick: levels set, 4 cycles low, 4 cycles high, noise elsewhere
  task automatic tick(logic a, logic b);
    @(negedge clk_sys);
    src = 15'($random(seed));
    src[idx(sel_a)] = a;
    src[idx(sel_b)] = b;
    tbs = 5'($random(seed));
    tbs[tb_sel] = 1'h0;
    repeat (4) @(negedge clk_sys);
    tbs[tb_sel] = 1'h1;
    repeat (3) @(negedge clk_sys);
  endtask

  // one measurement, A edge fixed at tick 4, model judged per tick
  task automatic run(logic [4:0] ca, logic [4:0] cb, int pb, int off);
    int   d;
    int   lastb;
    int   k;
    int   expv;
    logic eb;
    logic ovf;
    logic done;
    sel_a = ca;
    sel_b = cb;
    lastb = -1;
    d = 99999;
    expv = 0;
    ovf = 1'h0;
    done = 1'h0;
    tick(fa, blv(0, pb, off));
    pulse(4'h1);
    for (int t = 1; t < 1100 && !done; t++) begin
      if (t < 1000)
        chk_flag("busy", 1'h1, st1[POM_ST_BUSY]);
      tick(fa ^ (t >= 4), blv(t, pb, off));
      eb = blv(t, pb, off) != blv(t - 1, pb, off) && blv(t, pb, off) != (fb ^ inv);
      k = t - 4;
      if (k == 0)
        d = (lastb < 0) ? 99999 : 4 - lastb;
      else if (k < 0 && eb)
        lastb = t;
      else if (k > 0 && ((eb && k <= d) || k > d || k >= 1025)) begin
        done = 1'h1;
        expv = (eb && k <= d) ? k : -d;
        ovf = expv > 1023 || expv < -1024 || k >= 1025;
      end
    end
    for (int w = 0; w < 40 && st1[POM_ST_BUSY] !== 1'h0; w++)
      @(negedge clk_sys);
    if (st1[POM_ST_BUSY] !== 1'h0) begin
      error_cnt++;
      $display("ERROR busy expected 0 seen %b", st1[POM_ST_BUSY]);
      conclude();
    end
    if (!done) begin
      error_cnt++;
      $display("ERROR completion expected 1 seen 0");
      conclude();
    end
    if (!ovf)
      last_res = expv;
    chk_flag("busy", 1'h0, st1[POM_ST_BUSY]);
    chk_flag("ready", 1'h1, st1[POM_ST_RDY]);
    chk_flag("overflow", ovf, st1[POM_ST_OVF]);
    chk_res("offset", 11'(last_res), {st1[7:5], st2});
    pulse(4'h4);
    chk_flag("ready", 1'h0, st1[POM_ST_RDY]);
    pulse(4'h8);
    chk_flag("overflow", 1'h0, st1[POM_ST_OVF]);
    $display("run a %h b %h tb %0d period %0d finished", ca, cb, tb_sel, pb);
  endtask

  // main sequence
  initial begin
    int pb;
    int off;
    repeat (20) @(negedge clk_sys);
    rst = 1'h0;
    chk_res("status one", 11'h000, {3'h0, st1});
    chk_res("status two", 11'h000, {3'h0, st2});
    for (int i = 0; i < 15; i++) begin
      tb_sel = 3'(i % 5);
      {fa, fb, inv} = 3'($random(seed));
      pb = 10 + rnd(16); // timebase 10x to 25x faster than B
      off = (i % 4 == 2) ? (((fb ^ inv) ? pb / 2 : 0) + 4 * pb - 4) % pb : rnd(pb);
      run(i < 2 ? 5'h11 - 5'(i) : ((i % 2) ? 5'(i % 4) : 5'(8 + i % 8)), 5'h10 + 5'(i % 3), pb, off);
    end
    tb_sel = 3'h1;
    run(5'h08, 5'h01, 0, 0);
    pulse(4'h1);
    tick(fa, 1'h0);
    @(negedge clk_sys);
    strb = 4'h2;
    @(negedge clk_sys);
    strb = 4'h1;
    chk_flag("busy", 1'h0, st1[POM_ST_BUSY]);
    chk_res("offset", 11'h000, {st1[7:5], st2});
    @(negedge clk_sys);
    strb = 4'h0;
    chk_flag("busy", 1'h1, st1[POM_ST_BUSY]);
    pulse(4'h2);
    chk_flag("busy", 1'h0, st1[POM_ST_BUSY]);
    $display("abort and restart finished");
    conclude();
  end
endmodule // pom_meter_bench
